// ===== hw/rsb_consts.vh
// Register offsets, field positions, reset values and timing counts of the synth buffer bank.
`ifndef RSB_CONSTS_VH
`define RSB_CONSTS_VH
`define RSB_IDX_SWING 8'h18
`define RSB_IDX_CURRENT 8'h19
`define RSB_IDX_BW 8'h1a
`define RSB_IDX_CAL 8'h1b
`define RSB_IDX_POWER 8'h1c
`define RSB_IDX_STATUS 8'h1d
`define RSB_ADDR_SWING 12'h060
`define RSB_ADDR_CURRENT 12'h064
`define RSB_ADDR_BW 12'h068
`define RSB_ADDR_CAL 12'h06c
`define RSB_ADDR_POWER 12'h070
`define RSB_ADDR_STATUS 12'h074
`define RSB_RST_SWING 8'he1
`define RSB_RST_CURRENT 8'h65
`define RSB_RST_BW 8'h86
`define RSB_RST_CAL 8'h05
`define RSB_RST_POWER 8'h0f
`define RSB_CAL_START_BIT 7
`define RSB_CAL_DUAL_BIT 6
`define RSB_CAL_WAIT_HI 5
`define RSB_CAL_WAIT_LO 4
`define RSB_CAL_WMASK 8'hf7
`define RSB_CAL_WAIT0 32'd90000
`define RSB_CAL_WAIT1 32'd110000
`define RSB_CAL_WAIT2 32'd130000
`define RSB_CAL_WAIT3 32'd200000
`endif

// ===== hw/rsb_cal_timer.v
// Calibration run timer started by a rising edge of the start bit.
`timescale 1ns/10ps
module rsb_cal_timer #(
    parameter WAIT0 = 90000,
    parameter WAIT1 = 110000,
    parameter WAIT2 = 130000,
    parameter WAIT3 = 200000
) (
    input wire aclk,
    input wire aresetn,
    input wire start_level,
    input wire [1:0] wait_code,
    output reg busy,
    output reg done
);
    reg start_prev;
    reg [17:0] count;
    reg [17:0] next_count;
    always @* begin
        case (wait_code)
            2'h0: next_count = WAIT0[17:0] - 18'h1;
            2'h1: next_count = WAIT1[17:0] - 18'h1;
            2'h2: next_count = WAIT2[17:0] - 18'h1;
            default: next_count = WAIT3[17:0] - 18'h1;
        endcase
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            start_prev <= 1'b0;
            count <= 18'h0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            start_prev <= start_level;
            done <= 1'b0;
            if (start_level && !start_prev) begin
                // A new rising edge restarts the run with the current wait code.
                busy <= 1'b1;
                count <= next_count;
            end else if (busy) begin
                if (count == 18'h0) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - 18'h1;
                end
            end
        end
    end
endmodule // rsb_cal_timer

// ===== hw/rsb_regs.v
// AXI4-Lite register bank for synthesizer buffers, calibration and amplifier power.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "rsb_consts.vh"
module rsb_regs #(
    parameter CAL_WAIT0 = 90000,
    parameter CAL_WAIT1 = 110000,
    parameter CAL_WAIT2 = 130000,
    parameter CAL_WAIT3 = 200000
) (
    input wire aclk,
    input wire aresetn,
    input wire [11:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire freq_select,
    output reg [1:0] prescaler_swing,
    output reg [2:0] rx_lo_swing,
    output reg [2:0] tx_lo_swing,
    output reg [1:0] prescaler_current,
    output reg [2:0] rx_lo_current,
    output reg [2:0] tx_lo_current,
    output reg [7:0] loop_bandwidth_factor,
    output reg [3:0] calibration_dac_start,
    output reg [3:0] high_array_power,
    output reg [3:0] low_array_power,
    output wire calibration_busy,
    output reg store_set_a,
    output reg store_set_b
);
    // ************************************************************
    // Register storage
    // ************************************************************
    reg [7:0] lo_buffer_swing;
    reg [7:0] lo_buffer_current;
    reg [7:0] loop_bandwidth_scale;
    reg [7:0] synth_calibration_control;
    reg [7:0] amplifier_output_power;
    reg [11:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg aw_held;
    reg w_held;
    wire cal_done;
    wire do_write;
    wire do_read;
    reg [31:0] next_rdata;
    reg next_rok;
    reg wr_ok;
    reg we_swing;
    reg we_current;
    reg we_bw;
    reg we_cal;
    reg we_power;

    // ************************************************************
    // Write channel
    // ************************************************************
    // Address and data are caught separately so either may come first.
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always @* begin
        case (aw_addr)
            `RSB_ADDR_SWING,
            `RSB_ADDR_CURRENT,
            `RSB_ADDR_BW,
            `RSB_ADDR_CAL,
            `RSB_ADDR_POWER,
            `RSB_ADDR_STATUS: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // ************************************************************
    // Write decode
    // ************************************************************
    // Only byte lane 0 carries register data; other lanes are ignored.
    always @* begin
        we_swing = 1'b0;
        we_current = 1'b0;
        we_bw = 1'b0;
        we_cal = 1'b0;
        we_power = 1'b0;
        if (do_write && w_strb[0]) begin
            case (aw_addr)
                `RSB_ADDR_SWING: we_swing = 1'b1;
                `RSB_ADDR_CURRENT: we_current = 1'b1;
                `RSB_ADDR_BW: we_bw = 1'b1;
                `RSB_ADDR_CAL: we_cal = 1'b1;
                `RSB_ADDR_POWER: we_power = 1'b1;
                default: we_swing = 1'b0;
            endcase
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[11:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Register storage update
    // ************************************************************
    // One process per word, so a write enable can only ever move its own word.
    always @(posedge aclk) begin
        if (!aresetn) begin
            lo_buffer_swing <= `RSB_RST_SWING;
        end else if (we_swing) begin
            lo_buffer_swing <= w_data[7:0];
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            lo_buffer_current <= `RSB_RST_CURRENT;
        end else if (we_current) begin
            lo_buffer_current <= w_data[7:0];
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            loop_bandwidth_scale <= `RSB_RST_BW;
        end else if (we_bw) begin
            loop_bandwidth_scale <= w_data[7:0];
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            synth_calibration_control <= `RSB_RST_CAL;
        end else if (we_cal) begin
            // The reserved bit 3 is kept at zero.
            synth_calibration_control <=
                w_data[7:0] & `RSB_CAL_WMASK;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            amplifier_output_power <= `RSB_RST_POWER;
        end else if (we_power) begin
            amplifier_output_power <= w_data[7:0];
        end
    end

    // ************************************************************
    // Read channel
    // ************************************************************
    assign s_axi_arready = !s_axi_rvalid;
    assign do_read = s_axi_arvalid && s_axi_arready;

    always @* begin
        next_rdata = 32'h0;
        next_rok = 1'b1;
        case ({s_axi_araddr[11:2], 2'h0})
            `RSB_ADDR_SWING: next_rdata = {24'h0, lo_buffer_swing};
            `RSB_ADDR_CURRENT: next_rdata = {24'h0, lo_buffer_current};
            `RSB_ADDR_BW: next_rdata = {24'h0, loop_bandwidth_scale};
            `RSB_ADDR_CAL: next_rdata = {24'h0, synth_calibration_control};
            `RSB_ADDR_POWER: next_rdata = {24'h0, amplifier_output_power};
            `RSB_ADDR_STATUS: next_rdata = {31'h0, calibration_busy};
            default: next_rok = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else if (do_read) begin
            // Reads only sample storage and never alter it.
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rok ? 2'h0 : 2'h2;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ************************************************************
    // Field outputs and calibration
    // ************************************************************
    rsb_cal_timer #(
        .WAIT0(CAL_WAIT0),
        .WAIT1(CAL_WAIT1),
        .WAIT2(CAL_WAIT2),
        .WAIT3(CAL_WAIT3)
    ) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .start_level(synth_calibration_control[`RSB_CAL_START_BIT]),
        .wait_code(synth_calibration_control[`RSB_CAL_WAIT_HI:`RSB_CAL_WAIT_LO]),
        .busy(calibration_busy),
        .done(cal_done)
    );

    always @(posedge aclk) begin
        if (!aresetn) begin
            prescaler_swing <= 2'h3;
            rx_lo_swing <= 3'h4;
            tx_lo_swing <= 3'h1;
        end else begin
            prescaler_swing <= lo_buffer_swing[7:6];
            rx_lo_swing <= lo_buffer_swing[5:3];
            tx_lo_swing <= lo_buffer_swing[2:0];
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            prescaler_current <= 2'h1;
            rx_lo_current <= 3'h4;
            tx_lo_current <= 3'h5;
        end else begin
            prescaler_current <= lo_buffer_current[7:6];
            rx_lo_current <= lo_buffer_current[5:3];
            tx_lo_current <= lo_buffer_current[2:0];
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            loop_bandwidth_factor <= 8'h86;
            calibration_dac_start <= 4'h6;
        end else begin
            loop_bandwidth_factor <= loop_bandwidth_scale;
            calibration_dac_start <= {1'b0, synth_calibration_control[2:0]} + 4'h1;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            high_array_power <= 4'h0;
            low_array_power <= 4'hf;
        end else begin
            high_array_power <= amplifier_output_power[7:4];
            low_array_power <= amplifier_output_power[3:0];
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            store_set_a <= 1'b0;
            store_set_b <= 1'b0;
        end else begin
            // When a run completes, A and B pulse once if the dual bit is set, else only A (freq_select low) or B (high).
            store_set_a <= cal_done &&
                (synth_calibration_control[`RSB_CAL_DUAL_BIT] || !freq_select);
            store_set_b <= cal_done &&
                (synth_calibration_control[`RSB_CAL_DUAL_BIT] || freq_select);
        end
    end
endmodule // rsb_regs

// ===== tb/rsb_regs_checker.sv
// Port-level assertions for the synth buffer register bank.
`timescale 1ns/10ps
module rsb_regs_checker (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire [3:0] calibration_dac_start,
    input wire calibration_busy,
    input wire store_set_a,
    input wire store_set_b
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ****************
    // Handshake rules
    // ****************
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write accepted while response pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    // ****************
    // Calibration rules, handshake covers and store covers
    // ****************
    a_dac_range: assert property (calibration_dac_start >= 4'h1
        && calibration_dac_start <= 4'h8)
        else $error("dac start out of range");
    a_store_pulse: assert property (store_set_a || store_set_b |=>
        !store_set_a && !store_set_b)
        else $error("store pulse too long");
    a_store_idle: assert property (store_set_a || store_set_b |-> !calibration_busy)
        else $error("store during run");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_dual: cover property (store_set_a && store_set_b);
    c_single: cover property (store_set_b && !store_set_a);
endmodule // rsb_regs_checker

// ===== tb/rsb_regs_bench.sv
// Self-checking bench for the synth buffer register bank.
`timescale 1ns/10ps
module rsb_regs_bench;
    reg aclk = 0, aresetn = 0, freq_select = 0;
    reg [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    reg [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
    reg [31:0] s_axi_wdata = 0;
    reg [3:0] s_axi_wstrb = 4'hf;
    reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    reg s_axi_arvalid = 0, s_axi_rready = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp, prescaler_swing, prescaler_current;
    wire [31:0] s_axi_rdata;
    wire [2:0] rx_lo_swing, tx_lo_swing, rx_lo_current, tx_lo_current;
    wire [7:0] loop_bandwidth_factor;
    wire [3:0] calibration_dac_start, high_array_power, low_array_power;
    wire calibration_busy, store_set_a, store_set_b;
    integer n_errors = 0, n_tests = 0, nb = 0, na = 0, nbb = 0, i;
    integer b0, a0, bb0;
    reg [31:0] d;
    reg [1:0] r;
    reg [7:0] wv [0:4];
    reg [7:0] rv [0:4];
    rsb_regs #(.CAL_WAIT0(10), .CAL_WAIT1(12), .CAL_WAIT2(14), .CAL_WAIT3(20)) dut (.*);
    always #2.5 aclk = ~aclk;
    // Counting starts after reset so an unknown output never poisons the totals.
    always @(posedge aclk) begin
        if (aresetn) begin
            nb <= nb + (calibration_busy === 1'b1);
            na <= na + (store_set_a === 1'b1);
            nbb <= nbb + (store_set_b === 1'b1);
        end
    end
    task chk(input [31:0] s, input [31:0] e);
        n_tests = n_tests + 1;
        if (s !== e) begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input [11:0] a, input [7:0] v);
        reg ad, wd;
        ad = 0;
        wd = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (s_axi_awready && !ad) begin
                ad = 1;
                s_axi_awvalid <= 0;
            end
            if (s_axi_wready && !wd) begin
                wd = 1;
                s_axi_wvalid <= 0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task rd(input [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    task t_regs;
        for (i = 0; i < 5; i = i + 1) begin
            rd(12'h060 + 4 * i);
            chk(d, {24'h0, rv[i]});
            chk(r, 2'b00);
        end
    endtask
    task t_write;
        for (i = 0; i < 5; i = i + 1) wr(12'h060 + 4 * i, wv[i]);
        repeat (2) @(posedge aclk);
        chk({prescaler_swing, rx_lo_swing, tx_lo_swing}, 8'h14);
        chk({prescaler_current, rx_lo_current, tx_lo_current}, 8'hd2);
        chk(loop_bandwidth_factor, 8'h5a);
        chk({high_array_power, low_array_power, calibration_dac_start}, 12'hf05);
        rv[0] = 8'h14;
        rv[1] = 8'hd2;
        rv[2] = 8'h5a;
        rv[3] = 8'h34;
        rv[4] = 8'hf0;
        t_regs;
        $display("test write done");
    endtask
    task t_unmapped;
        wr(12'h07c, 8'h55);
        chk(r, 2'b10);
        rd(12'h07c);
        chk(d, 32'h0);
        chk(r, 2'b10);
        $display("test unmapped done");
    endtask
    task t_cal(input [7:0] v, input fs, input integer len, input integer ea, input integer eb);
        freq_select <= fs;
        wr(12'h06c, v & 8'h7f);
        b0 = nb;
        a0 = na;
        bb0 = nbb;
        wr(12'h06c, v);
        while (calibration_busy !== 1'b1) @(posedge aclk);
        rd(12'h074);
        chk(d, 32'h1);
        while (calibration_busy !== 1'b0) @(posedge aclk);
        repeat (3) @(posedge aclk);
        chk(nb - b0, len);
        chk(na - a0, ea);
        chk(nbb - bb0, eb);
        $display("test calibration done");
    endtask
    task end_of_test;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        wv[0] = 8'h14;
        wv[1] = 8'hd2;
        wv[2] = 8'h5a;
        wv[3] = 8'h3c;
        wv[4] = 8'hf0;
        rv[0] = 8'he1;
        rv[1] = 8'h65;
        rv[2] = 8'h86;
        rv[3] = 8'h05;
        rv[4] = 8'h0f;
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        chk({prescaler_swing, rx_lo_swing, tx_lo_swing}, 8'he1);
        chk({prescaler_current, rx_lo_current, tx_lo_current}, 8'h65);
        chk({loop_bandwidth_factor, calibration_dac_start}, 12'h866);
        chk({high_array_power, low_array_power, calibration_busy}, 9'h01e);
        t_regs;
        $display("test defaults done");
        t_write;
        t_unmapped;
        t_cal(8'hc4, 1'b0, 10, 1, 1);
        t_cal(8'ha4, 1'b1, 14, 0, 1);
        t_cal(8'hb4, 1'b0, 20, 1, 0);
        t_cal(8'h94, 1'b1, 12, 0, 1);
        end_of_test;
    end
    initial begin
        #20000;
        n_errors = n_errors + 1;
        end_of_test;
    end
endmodule // rsb_regs_bench
bind rsb_regs rsb_regs_checker u_chk (.*);
